// File: logic/sector_protection_unit.v
// Per-sector persistent and dynamic protection with password gate
`timescale 1ns/1ns
`include "sector_guard_defs.vh"
module sector_protection_unit (
  input  wire                   clk_i,
  input  wire                   reset_i,
  input  wire                   por_i,
  input  wire                   soft_reset_i,
  input  wire                   link_clk_i,
  input  wire                   cmd_valid_i,
  input  wire [`SG_OP_W-1:0]    cmd_op_i,
  input  wire [`SG_SECT_W-1:0]  cmd_sector_i,
  input  wire [`SG_CFG_W-1:0]   cmd_data_i,
  input  wire [`SG_PW_W-1:0]    cmd_pw_i,
  input  wire                   write_latch_bit_i,
  input  wire [`SG_SECT_W-1:0]  query_sector_i,
  output reg                    cmd_done_o,
  output reg                    cmd_fail_o,
  output reg  [`SG_PW_W-1:0]    rd_data_o,
  output reg                    write_in_progress_o,
  output reg                    prog_error_o,
  output reg                    sector_protected_o,
  output reg  [`SG_CFG_W-1:0]   protection_mode_config_o,
  output reg  [`SG_GATE_W-1:0]  persistent_lock_gate_o
);

  // ********************************
  // States
  // ********************************
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_BUSY  = 4'b0010;
  localparam [3:0] ST_FAILW = 4'b0100;
  localparam [3:0] ST_DONE  = 4'b1000;

  // ********************************
  // Link clock edge detect
  // ********************************
  wire link_clk_s;
  reg  link_clk_d_r;
  wire link_rise;

  sg_sync2 u_link_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (link_clk_i),
    .q_o     (link_clk_s)
  );

  always @(posedge clk_i) begin
    if (reset_i) begin
      link_clk_d_r <= 1'b0;
    end else begin
      link_clk_d_r <= link_clk_s;
    end
  end
  assign link_rise = link_clk_s & ~link_clk_d_r;

  // ********************************
  // Host level inputs, synchronised
  // ********************************
  wire valid_s;
  wire latch_s;
  wire soft_s;

  sg_sync2 u_valid_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (cmd_valid_i),
    .q_o     (valid_s)
  );

  sg_sync2 u_latch_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (write_latch_bit_i),
    .q_o     (latch_s)
  );

  sg_sync2 u_soft_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (soft_reset_i),
    .q_o     (soft_s)
  );

  // ********************************
  // Storage
  // ********************************
  reg [`SG_CFG_W-1:0]   cfg_r;
  reg [`SG_NSECT-1:0]   plb_r;
  reg [`SG_NSECT-1:0]   dyb_r;
  reg [`SG_PW_W-1:0]    pw_r;
  reg                   gate_r;
  reg                   perr_r;
  reg [3:0]             state_r;
  reg [`SG_OP_W-1:0]    op_r;
  reg [`SG_SECT_W-1:0]  sect_r;
  reg [`SG_CFG_W-1:0]   data_r;
  reg [`SG_PW_W-1:0]    pw_in_r;
  reg                   fail_r;
  reg                   pw_match_r;

  wire [1:0] mode        = cfg_r[`SG_MODE_HI:`SG_MODE_LO];
  wire       pass_mode   = (mode == `SG_MODE_PASS);
  wire       mode_chosen = (mode != `SG_MODE_NONE);

  // ********************************
  // Busy timer
  // ********************************
  reg                   tmr_load;
  reg [`SG_TIMER_W-1:0] tmr_count;
  wire                  tmr_busy;
  wire                  tmr_done;

  sg_busy_timer u_timer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .abort_i (1'b0),
    .busy_o  (tmr_busy),
    .done_o  (tmr_done)
  );

  // ********************************
  // Command acceptance and dispatch
  // ********************************
  wire take = valid_s & link_rise & (state_r == ST_IDLE);
  wire [1:0] new_mode = cmd_data_i[`SG_MODE_HI:`SG_MODE_LO];

  always @* begin
    tmr_load  = 1'b0;
    tmr_count = `SG_VERIFY_CYC;
    if (take) begin
      case (cmd_op_i)
        `SG_OP_CFG_PROG, `SG_OP_PLB_PROG: begin
          tmr_load  = 1'b1;
          tmr_count = `SG_PAGE_CYC;
        end
        `SG_OP_PW_PROG: begin
          tmr_load  = ~pass_mode;
          tmr_count = `SG_PAGE_CYC;
        end
        `SG_OP_PLB_ERASE: begin
          tmr_load  = 1'b1;
          tmr_count = `SG_ERASE_CYC;
        end
        `SG_OP_PW_UNLOCK: begin
          tmr_load  = 1'b1;
          tmr_count = `SG_VERIFY_CYC;
        end
        default: begin
          tmr_load  = 1'b0;
        end
      endcase
    end else if (state_r == ST_BUSY && tmr_done && op_r == `SG_OP_PW_UNLOCK
                 && !pw_match_r) begin
      tmr_load  = 1'b1;
      tmr_count = `SG_UNLOCK_CYC;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      state_r    <= ST_IDLE;
      op_r       <= {`SG_OP_W{1'b0}};
      sect_r     <= {`SG_SECT_W{1'b0}};
      data_r     <= {`SG_CFG_W{1'b0}};
      pw_in_r    <= {`SG_PW_W{1'b0}};
      fail_r     <= 1'b0;
      pw_match_r <= 1'b0;
      perr_r     <= 1'b0;
      dyb_r      <= {`SG_NSECT{1'b1}};
      cmd_done_o <= 1'b0;
      cmd_fail_o <= 1'b0;
      rd_data_o  <= {`SG_PW_W{1'b0}};
    end else begin
      cmd_done_o <= 1'b0;
      if (soft_s) begin
        dyb_r <= {`SG_NSECT{1'b1}};
      end
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            op_r    <= cmd_op_i;
            sect_r  <= cmd_sector_i;
            data_r  <= cmd_data_i;
            pw_in_r <= cmd_pw_i;
            fail_r  <= 1'b0;
            perr_r  <= 1'b0;
            case (cmd_op_i)
              `SG_OP_CFG_PROG: begin
                fail_r <= mode_chosen || !latch_s ||
                          (new_mode == `SG_MODE_ILLEGAL);
                state_r <= ST_BUSY;
              end
              `SG_OP_PLB_PROG, `SG_OP_PLB_ERASE: begin
                fail_r  <= !gate_r || !latch_s;
                state_r <= ST_BUSY;
              end
              `SG_OP_PW_PROG: begin
                fail_r  <= !latch_s;
                state_r <= pass_mode ? ST_IDLE : ST_BUSY;
              end
              `SG_OP_PW_UNLOCK: begin
                pw_match_r <= (cmd_pw_i == pw_r);
                state_r    <= ST_BUSY;
              end
              `SG_OP_DYN_WRITE: begin
                dyb_r[cmd_sector_i] <= cmd_data_i[0];
                state_r <= ST_DONE;
              end
              `SG_OP_PLB_READ: begin
                rd_data_o <= {{(`SG_PW_W-1){1'b0}}, plb_r[cmd_sector_i]};
                state_r   <= ST_DONE;
              end
              `SG_OP_DYN_READ: begin
                rd_data_o <= {{(`SG_PW_W-1){1'b0}}, dyb_r[cmd_sector_i]};
                state_r   <= ST_DONE;
              end
              `SG_OP_GATE_READ: begin
                rd_data_o <= {{(`SG_PW_W-1){1'b0}}, gate_r};
                state_r   <= ST_DONE;
              end
              `SG_OP_CFG_READ: begin
                rd_data_o <= {{(`SG_PW_W-`SG_CFG_W){1'b0}}, cfg_r};
                state_r   <= ST_DONE;
              end
              `SG_OP_PW_READ: begin
                if (!pass_mode) begin
                  rd_data_o <= pw_r;
                  state_r   <= ST_DONE;
                end
              end
              `SG_OP_GATE_CLR: begin
                state_r <= ST_DONE;
              end
              default: begin
                state_r <= ST_IDLE;
              end
            endcase
          end
        end
        ST_BUSY: begin
          if (tmr_done) begin
            if (op_r == `SG_OP_PW_UNLOCK && !pw_match_r) begin
              perr_r  <= 1'b1;
              fail_r  <= 1'b1;
              state_r <= ST_FAILW;
            end else begin
              perr_r  <= fail_r;
              state_r <= ST_DONE;
            end
          end
        end
        ST_FAILW: begin
          if (!tmr_busy) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          cmd_done_o <= 1'b1;
          cmd_fail_o <= fail_r;
          state_r    <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ********************************
  // Nonvolatile state and gate
  // ********************************
  wire finish_ok = (state_r == ST_BUSY) && tmr_done && !fail_r;

  always @(posedge clk_i) begin
    if (por_i) begin
      cfg_r <= `SG_CFG_RESET;
      plb_r <= {`SG_NSECT{1'b1}};
      pw_r  <= {`SG_PW_W{1'b1}};
    end else if (finish_ok) begin
      case (op_r)
        `SG_OP_CFG_PROG:  cfg_r  <= cfg_r & data_r;
        `SG_OP_PLB_PROG:  plb_r[sect_r] <= 1'b0;
        `SG_OP_PLB_ERASE: plb_r  <= {`SG_NSECT{1'b1}};
        `SG_OP_PW_PROG:   pw_r   <= pw_r & pw_in_r;
        default:          pw_r   <= pw_r;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      gate_r <= ~pass_mode;
    end else if (state_r == ST_BUSY && tmr_done && op_r == `SG_OP_PW_UNLOCK
                 && pw_match_r) begin
      gate_r <= 1'b1;
    end else if (state_r == ST_IDLE && take && cmd_op_i == `SG_OP_GATE_CLR) begin
      gate_r <= 1'b0;
    end
  end

  // ********************************
  // Registered outputs
  // ********************************
  always @(posedge clk_i) begin
    if (reset_i) begin
      write_in_progress_o      <= 1'b0;
      prog_error_o             <= 1'b0;
      sector_protected_o       <= 1'b1;
      protection_mode_config_o <= `SG_CFG_RESET;
      persistent_lock_gate_o   <= {`SG_GATE_W{1'b0}};
    end else begin
      write_in_progress_o      <= (state_r == ST_BUSY) || (state_r == ST_FAILW);
      prog_error_o             <= perr_r;
      sector_protected_o       <= ~(plb_r[query_sector_i] & dyb_r[query_sector_i]);
      protection_mode_config_o <= cfg_r;
      persistent_lock_gate_o   <= {{(`SG_GATE_W-1){1'b0}}, gate_r};
    end
  end
endmodule // sector_protection_unit

// File: logic/sector_guard_defs.vh
// Constants for the sector guard protection block
`ifndef SECTOR_GUARD_DEFS_VH
`define SECTOR_GUARD_DEFS_VH

// ********************************
// Geometry and widths
// ********************************
`define SG_SECT_W        6
`define SG_NSECT         64
`define SG_PW_W          64
`define SG_CFG_W         16
`define SG_GATE_W        8

// ********************************
// Mode-lock field in protection_mode_config
// ********************************
`define SG_MODE_HI       2
`define SG_MODE_LO       1
`define SG_MODE_NONE     2'b11
`define SG_MODE_PERS     2'b10
`define SG_MODE_PASS     2'b01
`define SG_MODE_ILLEGAL  2'b00
`define SG_CFG_RESET     16'hFFFF
`define SG_GATE_BIT      0

// ********************************
// Command codes on cmd_op_i
// ********************************
`define SG_OP_W          4
`define SG_OP_CFG_PROG   4'h1
`define SG_OP_PLB_PROG   4'h2
`define SG_OP_PLB_ERASE  4'h3
`define SG_OP_PLB_READ   4'h4
`define SG_OP_DYN_WRITE  4'h5
`define SG_OP_DYN_READ   4'h6
`define SG_OP_GATE_CLR   4'h7
`define SG_OP_GATE_READ  4'h8
`define SG_OP_PW_PROG    4'h9
`define SG_OP_PW_READ    4'hA
`define SG_OP_PW_UNLOCK  4'hB
`define SG_OP_CFG_READ   4'hC

// ********************************
// Timing
// ********************************
`define SG_CLK_MHZ       125
`define SG_PAGE_PROG_US  250
`define SG_SECT_ERASE_US 500
`define SG_UNLOCK_US     100
`define SG_UNLOCK_TOL_US 20
`define SG_TIMER_W       17
`define SG_PAGE_CYC      17'h0_7A12
`define SG_ERASE_CYC     17'h0_F424
`define SG_UNLOCK_CYC    17'h0_30D4
`define SG_VERIFY_CYC    17'h0_0004

`endif

// File: logic/sg_sync2.v
// Two-stage synchroniser for one level
`timescale 1ns/1ns
module sg_sync2 (
  input  wire clk_i,
  input  wire reset_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta_r;

  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // sg_sync2

// File: logic/sg_busy_timer.v
// Down counter that times an embedded operation
`timescale 1ns/1ns
`include "sector_guard_defs.vh"
module sg_busy_timer (
  input  wire                   clk_i,
  input  wire                   reset_i,
  input  wire                   load_i,
  input  wire [`SG_TIMER_W-1:0] count_i,
  input  wire                   abort_i,
  output wire                   busy_o,
  output wire                   done_o
);
  reg [`SG_TIMER_W-1:0] cnt_r;

  assign busy_o = (cnt_r != {`SG_TIMER_W{1'b0}});
  assign done_o = (cnt_r == {{(`SG_TIMER_W-1){1'b0}}, 1'b1});

  always @(posedge clk_i) begin
    if (reset_i || abort_i) begin
      cnt_r <= {`SG_TIMER_W{1'b0}};
    end else if (load_i) begin
      cnt_r <= count_i;
    end else if (busy_o) begin
      cnt_r <= cnt_r - {{(`SG_TIMER_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // sg_busy_timer

// File: tb/sector_guard_properties.sv
// Port-level assertions for the sector protection unit
`timescale 1ns/1ns
`include "sector_guard_defs.vh"
module sector_guard_properties (
  input wire                   clk_i,
  input wire                   reset_i,
  input wire                   cmd_done_o,
  input wire                   cmd_fail_o,
  input wire                   write_in_progress_o,
  input wire                   prog_error_o,
  input wire [`SG_CFG_W-1:0]   protection_mode_config_o,
  input wire [`SG_GATE_W-1:0]  persistent_lock_gate_o
);
  reg  [16:0] busy_cnt_r;
  wire [1:0]  mode = protection_mode_config_o[2:1];
  // ********************************
  // Busy length counter
  // ********************************
  always @(posedge clk_i) begin
    if (reset_i || !write_in_progress_o)
      busy_cnt_r <= 17'h0_0000;
    else
      busy_cnt_r <= busy_cnt_r + 17'h0_0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_done_one_pulse: assert property (cmd_done_o |=> !cmd_done_o)
    else $error("done pulse too long");
  a_busy_ends_done: assert property (cmd_done_o |=> !write_in_progress_o)
    else $error("busy after done");
  a_mode_never_zero: assert property (mode != 2'h0)
    else $error("mode bits both zero");
  a_mode_frozen: assert property (mode != 2'h3 |=> $stable(protection_mode_config_o))
    else $error("config changed after mode set");
  a_cfg_bits_fall: assert property
    ((protection_mode_config_o & ~$past(protection_mode_config_o)) == 16'h0000)
    else $error("config bit went back to one");
  a_gate_rise_pw: assert property
    ($rose(persistent_lock_gate_o[0]) && !$past(reset_i) && !$past(reset_i, 2)
     |-> mode == 2'h1)
    else $error("gate set outside password mode");
  a_fail_after_wait: assert property
    (cmd_done_o && cmd_fail_o |-> busy_cnt_r >= 17'h0_2710)
    else $error("failure reported too early");
  a_fail_sets_error: assert property (cmd_done_o && cmd_fail_o |-> prog_error_o)
    else $error("failure without error flag");
  a_busy_bounded: assert property (busy_cnt_r < 17'h0_F600)
    else $error("busy too long");
  c_fail: cover property (cmd_done_o && cmd_fail_o);
  c_gate_set: cover property ($rose(persistent_lock_gate_o[0]));
  c_pw_mode_done: cover property (mode == 2'h1 && cmd_done_o);
endmodule // sector_guard_properties

bind sector_protection_unit sector_guard_properties chk (
  .clk_i(clk_i), .reset_i(reset_i), .cmd_done_o(cmd_done_o), .cmd_fail_o(cmd_fail_o),
  .write_in_progress_o(write_in_progress_o), .prog_error_o(prog_error_o),
  .protection_mode_config_o(protection_mode_config_o),
  .persistent_lock_gate_o(persistent_lock_gate_o)
);

// File: tb/host_model.sv
// Host command master for the sector guard block
`timescale 1ns/1ns
`include "sector_guard_defs.vh"
module host_model (
  input  wire        clk_i,
  input  wire        done_i,
  output reg         link_clk_o,
  output reg         valid_o,
  output reg  [3:0]  op_o,
  output reg  [5:0]  sec_o,
  output reg  [15:0] data_o,
  output reg  [63:0] pw_o,
  output reg         latch_o
);
  initial begin
    {link_clk_o, valid_o, op_o, sec_o, data_o, pw_o, latch_o} = '0;
  end
  // ********************************
  // One link edge a frame, held to done or to the cycle limit
  // ********************************
  task issue(input [3:0] o, input [5:0] s, input [15:0] d, input [63:0] p,
             input integer lim, output reg got);
    integer n;
    begin
      got = 1'h0;
      n = 0;
      @(posedge clk_i);
      valid_o <= 1'h1;
      {op_o, sec_o, data_o, pw_o} <= {o, s, d, p};
      latch_o <= (o == `SG_OP_CFG_PROG) || (o == `SG_OP_PLB_PROG) ||
                 (o == `SG_OP_PLB_ERASE) || (o == `SG_OP_PW_PROG);
      fork
        begin
          #10 link_clk_o = 1'h1;
          #32 link_clk_o = 1'h0;
        end
      join_none
      while (!got && n < lim) begin
        @(posedge clk_i);
        n = n + 1;
        got = (done_i === 1'h1);
      end
      valid_o <= 1'h0;
      latch_o <= 1'h0;
      {op_o, sec_o, data_o, pw_o} <= ~{o, s, d, p};
    end
  endtask
endmodule // host_model

// File: tb/tb_sector_protection_unit.sv
// Self-checking bench for the sector protection unit
`timescale 1ns/1ns
`include "sector_guard_defs.vh"
`define CHECK(g, e) begin \
  total_checks = total_checks + 1; \
  if ((g) !== (e)) begin \
    errors = errors + 1; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, e); \
  end \
end
module tb_sector_protection_unit;
  typedef struct {
    logic [3:0]  op;
    logic [5:0]  sec;
    logic [15:0] data;
    logic [63:0] rd;
    logic        prot;
  } row_t;
  reg         clk_i = 1'h0;
  reg         reset_i = 1'h1;
  reg         por_i = 1'h1;
  reg         soft_i = 1'h0;
  reg  [5:0]  query_i = 6'h00;
  wire        lclk, valid, latch, done, fail, write_in_progress, perr, prot;
  wire [3:0]  op;
  wire [5:0]  sec;
  wire [15:0] data, cfg;
  wire [63:0] pw, rd;
  wire [7:0]  gate;
  integer     errors = 0;
  integer     total_checks = 0;
  integer     wip_cnt = 0;
  integer     wip_base = 0;
  integer     i;
  reg         got;
  row_t       rows [0:8];

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (write_in_progress === 1'h1) wip_cnt <= wip_cnt + 1;

  sector_protection_unit uut (
    .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i), .soft_reset_i(soft_i),
    .link_clk_i(lclk), .cmd_valid_i(valid), .cmd_op_i(op), .cmd_sector_i(sec),
    .cmd_data_i(data), .cmd_pw_i(pw), .write_latch_bit_i(latch),
    .query_sector_i(query_i), .cmd_done_o(done), .cmd_fail_o(fail), .rd_data_o(rd),
    .write_in_progress_o(write_in_progress), .prog_error_o(perr), .sector_protected_o(prot),
    .protection_mode_config_o(cfg), .persistent_lock_gate_o(gate));
  host_model host (
    .clk_i(clk_i), .done_i(done), .link_clk_o(lclk), .valid_o(valid), .op_o(op),
    .sec_o(sec), .data_o(data), .pw_o(pw), .latch_o(latch));

  task cmd(input [3:0] o, input [5:0] s, input [15:0] d, input [63:0] p, input integer l);
    host.issue(o, s, d, p, l, got);
  endtask
  task hard_reset;
    @(posedge clk_i);
    reset_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
  task query(input [5:0] s);
    @(posedge clk_i);
    query_i <= s;
    repeat (3) @(posedge clk_i);
  endtask
  task results;
    $display("errors %0d total_checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(100000 * 8);
    errors = errors + 1;
    results;
  end

  // ********************************
  // Test sequence
  // ********************************
  initial begin
    rows[0] = '{`SG_OP_DYN_WRITE, 6'h03, 16'h0000, 64'h0, 1'h1};
    rows[1] = '{`SG_OP_DYN_READ, 6'h03, 16'h0000, 64'h0, 1'h1};
    rows[2] = '{`SG_OP_DYN_WRITE, 6'h03, 16'h0001, 64'h0, 1'h0};
    rows[3] = '{`SG_OP_DYN_READ, 6'h03, 16'h0000, 64'h1, 1'h0};
    rows[4] = '{`SG_OP_DYN_WRITE, 6'h0A, 16'h0000, 64'h0, 1'h1};
    rows[5] = '{`SG_OP_PLB_READ, 6'h0A, 16'h0000, 64'h1, 1'h1};
    rows[6] = '{`SG_OP_GATE_READ, 6'h00, 16'h0000, 64'h1, 1'h0};
    rows[7] = '{`SG_OP_CFG_READ, 6'h00, 16'h0000, 64'h0_FFFF, 1'h0};
    rows[8] = '{`SG_OP_PW_READ, 6'h00, 16'h0000, {64{1'h1}}, 1'h0};
    repeat (20) @(posedge clk_i);
    reset_i <= 1'h0;
    por_i <= 1'h0;
    query(6'h00);
    `CHECK(cfg, 16'hFFFF)
    `CHECK(gate[0], 1'h1)
    `CHECK({prot, perr, write_in_progress}, 3'h0)
    for (i = 0; i < 9; i = i + 1) begin
      cmd(rows[i].op, rows[i].sec, rows[i].data, 64'h0, 50);
      query(rows[i].sec);
      `CHECK({got, fail}, 2'h2)
      if (rows[i].op != `SG_OP_DYN_WRITE) `CHECK(rd, rows[i].rd)
      `CHECK(prot, rows[i].prot)
    end
    cmd(`SG_OP_GATE_CLR, 6'h00, 16'h0000, 64'h0, 50);
    query(6'h0A);
    `CHECK({got, gate[0]}, 2'h2)
    soft_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    soft_i <= 1'h0;
    query(6'h0A);
    `CHECK(gate[0], 1'h0)
    `CHECK(prot, 1'h0)
    hard_reset;
    `CHECK(gate[0], 1'h1)
    wip_base = wip_cnt;
    cmd(`SG_OP_CFG_PROG, 6'h00, 16'hFFFB, 64'h0, `SG_PAGE_CYC + 100);
    query(6'h07);
    `CHECK({got, fail, cfg}, {2'h2, 16'hFFFB})
    `CHECK((wip_cnt - wip_base) >= `SG_PAGE_CYC, 1'h1)
    cmd(`SG_OP_PW_PROG, 6'h00, 16'h0000, 64'h0, 100);
    `CHECK(got, 1'h0)
    cmd(`SG_OP_PW_READ, 6'h00, 16'h0000, 64'h0, 100);
    `CHECK(got, 1'h0)
    hard_reset;
    `CHECK({gate[0], cfg}, {1'h0, 16'hFFFB})
    wip_base = wip_cnt;
    cmd(`SG_OP_PW_UNLOCK, 6'h00, 16'h0000, 64'h0, 2 * `SG_UNLOCK_CYC);
    `CHECK({got, fail, perr}, 3'h7)
    `CHECK((wip_cnt - wip_base) >= `SG_UNLOCK_CYC * 4 / 5, 1'h1)
    `CHECK((wip_cnt - wip_base) <= `SG_UNLOCK_CYC * 6 / 5, 1'h1)
    query(6'h07);
    `CHECK(gate[0], 1'h0)
    wip_base = wip_cnt;
    cmd(`SG_OP_PW_UNLOCK, 6'h00, 16'h0000, {64{1'h1}}, 50);
    query(6'h07);
    `CHECK({got, fail, perr, gate[0]}, 4'h9)
    `CHECK((wip_cnt - wip_base) < 20, 1'h1)
    cmd(`SG_OP_PLB_PROG, 6'h07, 16'h0000, 64'h0, `SG_PAGE_CYC + 100);
    query(6'h07);
    `CHECK({got, fail, prot}, 3'h5)
    query(6'h08);
    `CHECK(prot, 1'h0)
    cmd(`SG_OP_PLB_READ, 6'h07, 16'h0000, 64'h0, 50);
    `CHECK(rd, 64'h0)
    hard_reset;
    query(6'h07);
    `CHECK({prot, gate[0]}, 2'h2)
    results;
  end
endmodule // tb_sector_protection_unit
